// *** core/awc_pkg.sv ***
/*
 * Constants shared by the window comparator: the register bus geometry,
 * the register addresses on page zero, the field positions and reset values.
 * Assumes a byte-wide special-function-register bus and a 16-bit result word.
 */
package awc_pkg;

    // ------------------------------------------------------------------
    // Bus and data geometry
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned BYTE_W   = 8;
    localparam int unsigned RESULT_W = 16;

    // ------------------------------------------------------------------
    // Register addresses (page zero)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_GT_LO  = 8'hC3;
    localparam logic [ADDR_W-1:0] ADDR_GT_HI  = 8'hC4;
    localparam logic [ADDR_W-1:0] ADDR_LT_LO  = 8'hC5;
    localparam logic [ADDR_W-1:0] ADDR_LT_HI  = 8'hC6;
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'hE8;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned         FLAG_BIT    = 3;
    localparam logic [BYTE_W-1:0]   BYTE_RESET  = 8'h00;
    localparam logic [BYTE_W-1:0]   BYTE_ZERO   = 8'h00;

endpackage : awc_pkg

// *** core/awc_window_cmp.sv ***
/*
 * Combinational window test of one result word against the two limits.
 * Assumes result and limits share the same justification, so a plain
 * unsigned compare of the full words is correct for either alignment.
 */
`timescale 1ns/1ps

module awc_window_cmp
    import awc_pkg::*;
(
    input  wire logic [awc_pkg::RESULT_W-1:0] result_word,
    input  wire logic [awc_pkg::RESULT_W-1:0] greater_limit,
    input  wire logic [awc_pkg::RESULT_W-1:0] less_limit,
    output logic                              hit
);

    // ------------------------------------------------------------------
    // Window decision
    // ------------------------------------------------------------------

    // limits select mode
    // Mode comes only from which limit is larger; equal limits act as outside
    always_comb
    begin
        if (less_limit > greater_limit)
        begin
            hit = (result_word > greater_limit) && (result_word < less_limit);
        end
        else
        begin
            // strict outside test
            // Outside the span of the two limits: below the lower one or above the upper one
            hit = (result_word < less_limit) || (result_word > greater_limit);
        end
    end

endmodule : awc_window_cmp

// *** core/awc_window_top.sv ***
/*
 * Window comparator attached to the converter result word, with its limit
 * registers and control flag on the byte-wide register bus of page zero.
 * Assumes result_valid is a one-cycle pulse from converter logic on clk,
 * and that the bus issues at most one read or write per cycle.
 */
`timescale 1ns/1ps

// Summary of operation
// - Every completed result is checked against the limits by hardware alone.
// - Window flag sits in the control register, always readable, polled or interrupting.
// - Greater-than and less-than limits are writable high/low byte pairs.
// - Inside or outside mode follows only from the relative limit values.
// - Less-than above greater-than: flag when result strictly between them.
// - Otherwise flag when result below less-than or above greater-than.
// - Result compared unsigned; limits use the same justification as result.
// - Less-than high byte: read/write at 0xC6, resets to zero.
// - Less-than low byte: read/write at 0xC5, resets to zero.
module awc_window_top
    import awc_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic [awc_pkg::ADDR_W-1:0]   sfr_addr,
    input  wire logic [awc_pkg::BYTE_W-1:0]   sfr_wdata,
    input  wire logic                         sfr_we,
    input  wire logic                         sfr_re,
    output logic      [awc_pkg::BYTE_W-1:0]   sfr_rdata,
    input  wire logic [awc_pkg::RESULT_W-1:0] result_word,
    input  wire logic                         result_valid,
    output logic                              window_match_flag
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [BYTE_W-1:0]   gt_hi_r;
    logic [BYTE_W-1:0]   gt_hi_nxt;
    logic [BYTE_W-1:0]   gt_lo_r;
    logic [BYTE_W-1:0]   gt_lo_nxt;
    logic [BYTE_W-1:0]   lt_hi_r;
    logic [BYTE_W-1:0]   lt_hi_nxt;
    logic [BYTE_W-1:0]   lt_lo_r;
    logic [BYTE_W-1:0]   lt_lo_nxt;
    logic                flag_r;
    logic                flag_nxt;
    logic [BYTE_W-1:0]   rdata_r;
    logic [BYTE_W-1:0]   rdata_nxt;
    logic [RESULT_W-1:0] greater_limit;
    logic [RESULT_W-1:0] less_limit;
    logic                hit;
    logic                ctrl_wr;

    assign greater_limit = {gt_hi_r, gt_lo_r};
    assign less_limit    = {lt_hi_r, lt_lo_r};
    assign ctrl_wr       = sfr_we && (sfr_addr == ADDR_CTRL);

    // ------------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------------

    // full-word unsigned compare
    // Both sides carry the same justification, so no realignment is needed
    awc_window_cmp u_cmp
    (
        .result_word   (result_word),
        .greater_limit (greater_limit),
        .less_limit    (less_limit),
        .hit           (hit)
    );

    // ------------------------------------------------------------------
    // Register writes and flag
    // ------------------------------------------------------------------

    // Next values for the limit bytes and the sticky flag
    always_comb
    begin
        gt_hi_nxt = gt_hi_r;
        gt_lo_nxt = gt_lo_r;
        lt_hi_nxt = lt_hi_r;
        lt_lo_nxt = lt_lo_r;
        flag_nxt  = flag_r;
        if (sfr_we)
        begin
            unique case (sfr_addr)
                ADDR_GT_HI: gt_hi_nxt = sfr_wdata;
                ADDR_GT_LO: gt_lo_nxt = sfr_wdata;
                ADDR_LT_HI: lt_hi_nxt = sfr_wdata;
                ADDR_LT_LO: lt_lo_nxt = sfr_wdata;
                ADDR_CTRL:  flag_nxt  = flag_r & sfr_wdata[FLAG_BIT];
                default:    flag_nxt  = flag_r;
            endcase
        end
        // hardware sets flag
        // Set is applied last so a match in the clearing cycle is not lost
        if (result_valid && hit)
        begin
            flag_nxt = 1'b1;
        end
    end

    // Register stage; all bytes reset to zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gt_hi_r <= BYTE_RESET;
            gt_lo_r <= BYTE_RESET;
            lt_hi_r <= BYTE_RESET;
            lt_lo_r <= BYTE_RESET;
            flag_r  <= 1'b0;
        end
        else
        begin
            gt_hi_r <= gt_hi_nxt;
            gt_lo_r <= gt_lo_nxt;
            lt_hi_r <= lt_hi_nxt;
            lt_lo_r <= lt_lo_nxt;
            flag_r  <= flag_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Read data; held between reads, unmapped addresses read zero
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (sfr_re)
        begin
            unique case (sfr_addr)
                ADDR_GT_HI: rdata_nxt = gt_hi_r;
                ADDR_GT_LO: rdata_nxt = gt_lo_r;
                ADDR_LT_HI: rdata_nxt = lt_hi_r;
                ADDR_LT_LO: rdata_nxt = lt_lo_r;
                ADDR_CTRL:  rdata_nxt = BYTE_ZERO | (BYTE_W'(flag_r) << FLAG_BIT);
                default:    rdata_nxt = BYTE_ZERO;
            endcase
        end
    end

    // Read data and flag output both leave from flip-flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r <= BYTE_ZERO;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    assign sfr_rdata         = rdata_r;
    assign window_match_flag = flag_r;   // Interrupt or poll source

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_inside_hit;
        result_valid && (less_limit > greater_limit)
            && (result_word > greater_limit) && (result_word < less_limit);
    endsequence

    sequence s_outside_hit;
        result_valid && !(less_limit > greater_limit)
            && ((result_word < less_limit) || (result_word > greater_limit));
    endsequence

    chk_inside_sets_flag: assert property (s_inside_hit |=> window_match_flag)
        else $error("inside match did not set flag");

    chk_outside_sets_flag: assert property (s_outside_hit |=> window_match_flag)
        else $error("outside match did not set flag");

    chk_edge_no_set: assert property (
        (result_valid && !flag_r && !ctrl_wr && (less_limit > greater_limit)
            && (result_word == less_limit)) |=> !window_match_flag)
        else $error("flag set on result equal to limit");

    chk_flag_only_on_result: assert property (
        (!flag_r && !result_valid) |=> !window_match_flag)
        else $error("flag set without a result update");

    chk_flag_sticky: assert property (
        (flag_r && !ctrl_wr) |=> window_match_flag [*1])
        else $error("flag dropped without software clear");

    chk_clear_by_zero: assert property (
        (ctrl_wr && !sfr_wdata[FLAG_BIT] && !(result_valid && hit)) |=> !window_match_flag)
        else $error("writing zero did not clear flag");

    chk_lth_write: assert property (
        (sfr_we && (sfr_addr == ADDR_LT_HI)) |=> (less_limit[RESULT_W-1:BYTE_W] == $past(sfr_wdata)))
        else $error("less-than high byte not stored");

    chk_ltl_write: assert property (
        (sfr_we && (sfr_addr == ADDR_LT_LO)) |=> (less_limit[BYTE_W-1:0] == $past(sfr_wdata)))
        else $error("less-than low byte not stored");

    chk_flag_readback: assert property (
        (sfr_re && (sfr_addr == ADDR_CTRL)) |=> (sfr_rdata[FLAG_BIT] == $past(flag_r)))
        else $error("control read does not show flag");

    chk_pair_readback: assert property (
        (sfr_re && (sfr_addr == ADDR_GT_HI)) |=> (sfr_rdata == $past(greater_limit[RESULT_W-1:BYTE_W])))
        else $error("greater-than high byte readback wrong");

endmodule : awc_window_top

// *** testbench/awc_result_src.sv ***
/*
 * Model of the converter side: hands finished result words to the comparator.
 * Assumes the comparator samples result_word only while result_valid is high.
 */
`timescale 1ns/1ps

module awc_result_src
(
    input  wire logic                         clk,
    output logic      [awc_pkg::RESULT_W-1:0] result_word,
    output logic                              result_valid
);
    // ----------------------------------------------------------------
    // Result delivery
    // ----------------------------------------------------------------
    initial
    begin
        result_word  = 16'h0000;
        result_valid = 1'b0;
    end

    // One pulse per result; the word then flips so stale data never looks valid
    task automatic send(input logic [awc_pkg::RESULT_W-1:0] w);
        @(posedge clk);
        result_word  <= w;
        result_valid <= 1'b1;
        @(posedge clk);
        result_valid <= 1'b0;
        result_word  <= ~w;
    endtask : send
endmodule : awc_result_src

// *** testbench/awc_window_top_tb.sv ***
/*
 * Self-checking bench for the window comparator: limit table, sticky flag, registers.
 * Assumes the design's timing as handed over: registered read data, flag one cycle late.
 */
`timescale 1ns/1ps

module awc_window_top_tb;
    import awc_pkg::*;
    // ----------------------------------------------------------------
    // Clock, stimulus and design
    // ----------------------------------------------------------------
    typedef struct { logic [15:0] gt; logic [15:0] lt; logic [15:0] w; logic exp; } awc_row_s;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_we = 1'b0;
    logic        sfr_re = 1'b0;
    logic [7:0]  sfr_rdata;
    logic [15:0] result_word;
    logic        result_valid;
    logic        window_match_flag;
    int          num_errors = 0;
    int          checks_done = 0;
    awc_row_s    rows [11] = '{
        '{16'h0100, 16'h0200, 16'h0100, 1'b0}, '{16'h0100, 16'h0200, 16'h0101, 1'b1},
        '{16'h0100, 16'h0200, 16'h01FF, 1'b1}, '{16'h0100, 16'h0200, 16'h0200, 1'b0},
        '{16'h0200, 16'h0100, 16'h00FF, 1'b1}, '{16'h0200, 16'h0100, 16'h0100, 1'b0},
        '{16'h0200, 16'h0100, 16'h0200, 1'b0}, '{16'h0200, 16'h0100, 16'h0201, 1'b1},
        '{16'h0150, 16'h0150, 16'h0150, 1'b0}, '{16'h0150, 16'h0150, 16'h014F, 1'b1},
        '{16'h1000, 16'h2000, 16'h1800, 1'b1}};

    always #2 clk = ~clk;

    awc_window_top u_awc_window_top (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_rdata(sfr_rdata), .result_word(result_word),
        .result_valid(result_valid), .window_match_flag(window_match_flag));
    awc_result_src u_awc_result_src (.clk(clk), .result_word(result_word), .result_valid(result_valid));

    // ----------------------------------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_we    <= 1'b1;
        sfr_addr  <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_we    <= 1'b0;
    endtask : wr

    // Data lands on the edge that takes the strobe, so look just after it
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        sfr_re   <= 1'b1;
        sfr_addr <= a;
        @(posedge clk);
        sfr_re   <= 1'b0;
        #1 check(name, {8'h00, sfr_rdata}, {8'h00, exp});
    endtask : rd

    task automatic flag_is(input logic exp);
        #1 check("flag", {15'h0000, window_match_flag}, {15'h0000, exp});
    endtask : flag_is

    task automatic finish_test;
        if (num_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    // Watchdog: the whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        flag_is(1'b0);
        rd(ADDR_LT_HI, 8'h00, "lt_hi_reset");
        rd(ADDR_LT_LO, 8'h00, "lt_lo_reset");
        wr(ADDR_LT_HI, 8'h5A);
        wr(ADDR_LT_LO, 8'hA5);
        rd(ADDR_LT_HI, 8'h5A, "lt_hi_rw");
        rd(ADDR_LT_LO, 8'hA5, "lt_lo_rw");
        rd(8'h7F, 8'h00, "unmapped");
        // Table: limits set by bytes, flag cleared, one result compared
        foreach (rows[i])
        begin
            wr(ADDR_GT_HI, rows[i].gt[15:8]);
            wr(ADDR_GT_LO, rows[i].gt[7:0]);
            wr(ADDR_LT_HI, rows[i].lt[15:8]);
            wr(ADDR_LT_LO, rows[i].lt[7:0]);
            wr(ADDR_CTRL, 8'h00);
            u_awc_result_src.send(rows[i].w);
            flag_is(rows[i].exp);
        end
        // Sticky flag: cleared first, survives a miss and a write of one, cleared by zero
        wr(ADDR_CTRL, 8'h00);
        u_awc_result_src.send(16'h1000);
        flag_is(1'b0);
        u_awc_result_src.send(16'h1001);
        u_awc_result_src.send(16'h0005);
        flag_is(1'b1);
        wr(ADDR_CTRL, 8'h08);
        rd(ADDR_CTRL, 8'h08, "ctrl_flag");
        wr(ADDR_CTRL, 8'h00);
        flag_is(1'b0);
        rd(ADDR_CTRL, 8'h00, "ctrl_clear");
        // A match in the very cycle of a software clear must win
        fork
            wr(ADDR_CTRL, 8'h00);
            u_awc_result_src.send(16'h1001);
        join
        flag_is(1'b1);
        // Reset in mid-run: flag, read data and the less-than high byte return to zero
        rd(ADDR_LT_HI, 8'h20, "lt_hi_set");
        @(posedge clk);
        rst_n <= 1'b0;
        flag_is(1'b0);
        check("rdata_reset", {8'h00, sfr_rdata}, 16'h0000);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_LT_HI, 8'h00, "lt_hi_rereset");
        finish_test();
    end
endmodule : awc_window_top_tb
